// file: vts_pkg.sv
// package for the measuring-input supervision block: settings layout,
// register offsets, reset values and timing constants
// assumes a 250 MHz clock and an AHB-Lite slave with 32-bit words
// Function
// - negseq voltage without negseq current: voltage failure
// - three-phase voltage loss, no current change: failure
// - voltage failure blocks voltage-dependent protection
// - phase or negseq overcurrent pickup prevents block
// - voltage supervision only while line is live
// - inhibit: poles dead, overcurrent, negseq current, change
// - response select: blocking output or alarm only
// - reset select: manual or automatic clearing
// - voltage alarm after configurable operate delay
// - phase voltage detectors use configurable pickup
// - current supervision enable gates block and alarm
// - zero-sequence current above threshold: current block
// - residual voltage above threshold inhibits current check
// - current alarm after configurable delay following block
package vts_pkg;
  // register byte offsets
  localparam logic [7:0] VTS_OFS_CTRL = 8'h00;
  localparam logic [7:0] VTS_OFS_VPICK = 8'h04;
  localparam logic [7:0] VTS_OFS_IPH = 8'h08;
  localparam logic [7:0] VTS_OFS_INEG = 8'h0C;
  localparam logic [7:0] VTS_OFS_VDLY = 8'h10;
  localparam logic [7:0] VTS_OFS_CIN = 8'h14;
  localparam logic [7:0] VTS_OFS_CVN = 8'h18;
  localparam logic [7:0] VTS_OFS_CDLY = 8'h1C;
  localparam logic [7:0] VTS_OFS_STAT = 8'h20;
  localparam logic [7:0] VTS_OFS_IRQ = 8'h24;
  localparam logic [7:0] VTS_OFS_MASK = 8'h28;
  localparam logic [7:0] VTS_OFS_CMD = 8'h2C;
  // control register fields
  localparam int VTS_CTRL_BLOCK_BIT = 0;
  localparam int VTS_CTRL_AUTO_BIT = 1;
  localparam int VTS_CTRL_CEN_BIT = 2;
  // reset values
  localparam logic [2:0] VTS_CTRL_RST = 3'h3;
  localparam logic [15:0] VTS_THR_RST = 16'h0000;
  localparam logic [31:0] VTS_DLY_RST = 32'h0000_0000;
  // current failure alarm delay guidance, in milliseconds
  localparam int VTS_CDLY_GUIDE_MS = 5000;
  // change window: one power cycle at 50 Hz, in microseconds
  localparam int VTS_CYCLE_US = 20000;
  localparam int VTS_CLK_MHZ = 250;
  localparam int VTS_CYCLE_CLKS = VTS_CYCLE_US * VTS_CLK_MHZ;
  // interrupt bits: vfail, valarm, cblock, calarm
  localparam int VTS_NIRQ = 4;
endpackage

// file: vts_delay.sv
// on-delay timer: output rises once input held for the set count
// assumes count settings from registers on the same clock
`timescale 1ns/1ps
module vts_delay
  import vts_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // condition and setting
  input wire logic cond,
  input wire logic [31:0] limit,
  // delayed output
  output logic done
);
  logic [31:0] cnt_ff;
  wire at_limit = (cnt_ff >= limit);
  // counter restarts whenever the condition drops
  always_ff @(posedge clock)
  begin
    if (sys_rst || !cond)
      cnt_ff <= VTS_DLY_RST;
    else if (!at_limit)
      cnt_ff <= cnt_ff + 32'h0000_0001;
  end
  assign done = cond && at_limit;
endmodule

// file: vts_top.sv
// voltage and current input supervision with an AHB-Lite register file
// assumes detector flags come from other clock domains and are synchronised
// here; magnitudes are sampled samples from the measuring chain
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module vts_top
  import vts_pkg::*;
#(
  parameter int CHANGE_CLKS = VTS_CYCLE_CLKS
)
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measured magnitudes: one voltage per phase, the largest phase current, and sequence quantities
  input wire logic [15:0] va_mag,
  input wire logic [15:0] vb_mag,
  input wire logic [15:0] vc_mag,
  input wire logic [15:0] iph_max_mag,
  input wire logic [15:0] ineg_mag,
  input wire logic [15:0] izero_mag,
  input wire logic [15:0] vzero_mag,
  // detector flags from relay logic
  input wire logic vneg_detect,
  input wire logic ineg_present,
  input wire logic all_poles_dead,
  // supervision outputs
  output logic vfail_block,
  output logic vfail_alarm,
  output logic cfail_block,
  output logic cfail_alarm,
  output logic irq
);
  localparam int CW = $clog2(CHANGE_CLKS + 1);
  localparam logic [CW-1:0] CHANGE_LAST = CW'(CHANGE_CLKS - 1);

  // registers
  logic [2:0] ctrl_ff;
  logic [15:0] vpick_ff, iph_ff, ineg_ff, cin_ff, cvn_ff;
  logic [31:0] vdly_ff, cdly_ff;
  logic [VTS_NIRQ-1:0] irq_ff, mask_ff;
  logic aphase_ff, awr_ff;
  logic [7:0] aaddr_ff;
  logic [31:0] hrdata_ff;
  // synchronisers
  logic [2:0] sync1_ff, sync2_ff;
  // change detection and latch state
  logic [CW-1:0] win_ff;
  logic [15:0] iref_ff;
  logic change_ff;
  logic vlatch_ff;
  logic vblk_ff, valm_ff, cblk_ff, calm_ff, irq_out_ff;
  logic vlatch_d, vdone, cdone;

  // two flops on each pin-level flag before any logic looks at it
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {all_poles_dead, ineg_present, vneg_detect};
      sync2_ff <= sync1_ff;
    end
  end
  wire vneg_s = sync2_ff[0];
  wire ineg_s = sync2_ff[1];
  wire dead_s = sync2_ff[2];

  // bus decode
  wire take = hsel && hready && htrans[1];
  wire wr_en = aphase_ff && awr_ff;
  wire rd_take = take && !hwrite;
  wire cmd_wr = wr_en && (aaddr_ff == VTS_OFS_CMD);
  wire stat_rd = rd_take && (haddr[7:0] == VTS_OFS_IRQ);

  // address phase capture; one-cycle data phase, no wait states
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aphase_ff <= 1'b0;
      awr_ff <= 1'b0;
      aaddr_ff <= 8'h00;
    end
    else
    begin
      aphase_ff <= take;
      awr_ff <= hwrite;
      aaddr_ff <= {haddr[7:2], 2'b00};
    end
  end

  // setting registers written in the data phase
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= VTS_CTRL_RST;
      vpick_ff <= VTS_THR_RST;
      iph_ff <= VTS_THR_RST;
      ineg_ff <= VTS_THR_RST;
      cin_ff <= VTS_THR_RST;
      cvn_ff <= VTS_THR_RST;
      vdly_ff <= VTS_DLY_RST;
      cdly_ff <= VTS_DLY_RST;
      mask_ff <= '0;
    end
    else if (wr_en)
    begin
      unique case (aaddr_ff)
        VTS_OFS_CTRL: ctrl_ff <= hwdata[2:0];
        VTS_OFS_VPICK: vpick_ff <= hwdata[15:0];
        VTS_OFS_IPH: iph_ff <= hwdata[15:0];
        VTS_OFS_INEG: ineg_ff <= hwdata[15:0];
        VTS_OFS_VDLY: vdly_ff <= hwdata;
        VTS_OFS_CIN: cin_ff <= hwdata[15:0];
        VTS_OFS_CVN: cvn_ff <= hwdata[15:0];
        VTS_OFS_CDLY: cdly_ff <= hwdata;
        VTS_OFS_MASK: mask_ff <= hwdata[VTS_NIRQ-1:0];
        default: ;
      endcase
    end
  end

  wire cfg_block = ctrl_ff[VTS_CTRL_BLOCK_BIT];
  wire cfg_auto = ctrl_ff[VTS_CTRL_AUTO_BIT];
  wire cfg_cen = ctrl_ff[VTS_CTRL_CEN_BIT];

  // phase-current change over one power cycle; the reference is
  // refreshed each window, so a step shows until the end of the next window
  wire win_end = (win_ff == CHANGE_LAST);
  wire cur_diff = (iph_max_mag != iref_ff);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      win_ff <= '0;
      iref_ff <= 16'h0000;
      change_ff <= 1'b0;
    end
    else if (win_end)
    begin
      win_ff <= '0;
      iref_ff <= iph_max_mag;
      change_ff <= cur_diff;
    end
    else
    begin
      win_ff <= win_ff + CW'(1);
      change_ff <= change_ff || cur_diff;
    end
  end

  // detector levels
  wire va_low = (va_mag < vpick_ff);
  wire vb_low = (vb_mag < vpick_ff);
  wire vc_low = (vc_mag < vpick_ff);
  wire all_v_lost = va_low && vb_low && vc_low;
  wire iph_pick = (iph_max_mag > iph_ff);
  wire ineg_pick = (ineg_mag > ineg_ff);

  // voltage supervision inhibit and failure decision
  wire v_inhibit = dead_s || iph_pick || ineg_pick || ineg_s
                   || change_ff;
  wire vneg_fail = vneg_s && !ineg_s;
  wire v3_fail = all_v_lost && !change_ff;
  wire v_cond = !v_inhibit && (vneg_fail || v3_fail);

  // manual reset holds the indication until a reset command
  wire vclr_cmd = cmd_wr && hwdata[0];
  assign vlatch_d = v_cond
                    || (vlatch_ff && !cfg_auto && !vclr_cmd);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      vlatch_ff <= 1'b0;
    else
      vlatch_ff <= vlatch_d;
  end

  vts_delay u_vdly (
    .clock(clock),
    .sys_rst(sys_rst),
    .cond(vlatch_ff),
    .limit(vdly_ff),
    .done(vdone)
  );

  // current supervision: residual voltage above setting inhibits
  wire c_inhibit = (vzero_mag > cvn_ff);
  wire c_cond = cfg_cen && !c_inhibit && (izero_mag > cin_ff);

  vts_delay u_cdly (
    .clock(clock),
    .sys_rst(sys_rst),
    .cond(cblk_ff),
    .limit(cdly_ff),
    .done(cdone)
  );

  // outputs registered; alarm-only mode keeps vfail_block low
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      vblk_ff <= 1'b0;
      valm_ff <= 1'b0;
      cblk_ff <= 1'b0;
      calm_ff <= 1'b0;
    end
    else
    begin
      vblk_ff <= vlatch_ff && cfg_block;
      valm_ff <= vdone;
      cblk_ff <= c_cond;
      calm_ff <= cdone && cfg_cen;
    end
  end

  // sticky events; a read clears, but a new event in that cycle wins
  wire [VTS_NIRQ-1:0] ev = {cdone && cfg_cen, c_cond, vdone, vlatch_ff};
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_ff <= '0;
    else if (stat_rd)
      irq_ff <= ev;
    else
      irq_ff <= irq_ff | ev;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_out_ff <= 1'b0;
    else
      irq_out_ff <= |(irq_ff & mask_ff);
  end

  // read mux, answered in the data phase that follows the address
  wire [31:0] stat_word = {28'h000_0000, cblk_ff, calm_ff, valm_ff,
                           vlatch_ff};
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (haddr[7:0] & 8'hFC)
      VTS_OFS_CTRL: rd_mux = {29'h0000_0000, ctrl_ff};
      VTS_OFS_VPICK: rd_mux = {16'h0000, vpick_ff};
      VTS_OFS_IPH: rd_mux = {16'h0000, iph_ff};
      VTS_OFS_INEG: rd_mux = {16'h0000, ineg_ff};
      VTS_OFS_VDLY: rd_mux = vdly_ff;
      VTS_OFS_CIN: rd_mux = {16'h0000, cin_ff};
      VTS_OFS_CVN: rd_mux = {16'h0000, cvn_ff};
      VTS_OFS_CDLY: rd_mux = cdly_ff;
      VTS_OFS_STAT: rd_mux = stat_word;
      VTS_OFS_IRQ: rd_mux = {28'h000_0000, irq_ff};
      VTS_OFS_MASK: rd_mux = {28'h000_0000, mask_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      hrdata_ff <= 32'h0000_0000;
    else if (rd_take)
      hrdata_ff <= rd_mux;
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign vfail_block = vblk_ff;
  assign vfail_alarm = valm_ff;
  assign cfail_block = cblk_ff;
  assign cfail_alarm = calm_ff;
  assign irq = irq_out_ff;
endmodule

// file: vts_asserts.sv
// checker for the input supervision block, bound to vts_top
// assumes only the top module's ports; bind sits after endmodule
`timescale 1ns/1ps
module vts_asserts
  import vts_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // measured inputs
  input wire logic [15:0] izero_mag,
  input wire logic ineg_present,
  input wire logic all_poles_dead,
  // supervision outputs
  input wire logic vfail_block,
  input wire logic vfail_alarm,
  input wire logic cfail_block,
  input wire logic cfail_alarm,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a read taken on the bus this edge
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    !(vfail_block || vfail_alarm || cfail_block || cfail_alarm || irq))
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (rd_take && haddr[7:0] == 8'h30
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  ctrl_upper_a: assert property (rd_take && haddr[7:0] == VTS_OFS_CTRL
    |=> hrdata[31:3] == 29'h0) else $error("control upper bits set");
  // a sustained inhibit must keep a new block from appearing
  dead_no_block_a: assert property (
    all_poles_dead [*6] |-> !$rose(vfail_block))
    else $error("block rose with poles dead");
  ineg_no_block_a: assert property (
    ineg_present [*6] |-> !$rose(vfail_block))
    else $error("block rose with negseq current");
  izero_quiet_a: assert property (
    (izero_mag == 16'h0) [*3] |-> !cfail_block)
    else $error("current block without residual current");
  calarm_block_a: assert property (
    $rose(cfail_alarm) |-> cfail_block || $past(cfail_block))
    else $error("current alarm without block");
  cover property ($rose(vfail_block));
  cover property ($rose(cfail_alarm));
  cover property ($fell(irq));
endmodule

bind vts_top vts_asserts i_vts_asserts (.clock, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .izero_mag,
  .ineg_present, .all_poles_dead, .vfail_block, .vfail_alarm, .cfail_block,
  .cfail_alarm, .irq);

// file: vts_meas_model.sv
// measuring chain model: magnitudes and detector flags per scenario
// assumes the bench changes the scenario just after a clock edge
`timescale 1ns/1ps
module vts_meas_model
(
  // scenario select
  input wire logic [2:0] mode,
  input wire logic [1:0] resid,
  input wire logic [7:0] noise,
  // measured quantities
  output logic [15:0] va_mag,
  output logic [15:0] vb_mag,
  output logic [15:0] vc_mag,
  output logic [15:0] iph_max_mag,
  output logic [15:0] ineg_mag,
  output logic [15:0] izero_mag,
  output logic [15:0] vzero_mag,
  output logic vneg_detect,
  output logic ineg_present,
  output logic all_poles_dead
);
  wire logic lost = mode inside {3'h2, 3'h3, 3'h4};
  // healthy phases a and b carry noise; load current stays steady so no change
  assign va_mag = lost ? 16'h0 : 16'h4000 + {8'h0, noise};
  assign vb_mag = lost ? 16'h0 : 16'h4100 - {8'h0, noise};
  assign vc_mag = lost ? 16'h0 : 16'h4000;
  assign iph_max_mag = mode == 3'h3 ? 16'h3000 : 16'h0800;
  assign ineg_mag = mode == 3'h4 ? 16'h1800 : 16'h0;
  // residual quantities: 1 current only, 2 current with voltage
  assign izero_mag = resid != 2'h0 ? 16'h0300 : 16'h0;
  assign vzero_mag = resid == 2'h2 ? 16'h0300 : 16'h0;
  assign vneg_detect = mode inside {3'h1, 3'h5, 3'h6};
  assign ineg_present = mode == 3'h5;
  assign all_poles_dead = mode == 3'h6;
endmodule

// file: vt_ct_input_supervision_bench.sv
// bench for vts_top with a scenario model and an integer reference
// assumes an ahb-lite master here and a 16-cycle change window
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module vt_ct_input_supervision_bench;
  import vts_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic hreadyout, hresp, vfail_block, vfail_alarm, cfail_block;
  logic cfail_alarm, irq, vneg_detect, ineg_present, all_poles_dead;
  logic [15:0] va_mag, vb_mag, vc_mag, iph_max_mag, ineg_mag;
  logic [15:0] izero_mag, vzero_mag;
  logic [2:0] mode = 0;
  logic [1:0] resid = 0;
  logic [7:0] noise = 0;
  logic [2:0] pend = 0;
  int error_cnt = 0, checks_done = 0;
  int ctl, lat = 0, plat = 0, cc = 0, pcc = 0, mask = 0;
  int ctls [3] = '{7, 4, 3};
  // settings scaled to simulation cycles
  logic [7:0] cfg_a [7] = '{VTS_OFS_VPICK, VTS_OFS_IPH, VTS_OFS_INEG,
    VTS_OFS_VDLY, VTS_OFS_CIN, VTS_OFS_CVN, VTS_OFS_CDLY};
  logic [31:0] cfg_d [7] = '{32'h1000, 32'h2000, 32'h1000, 32'h1e,
    32'h0100, 32'h0200, 32'h28};
  always #2 clock = ~clock;
  vts_top #(.CHANGE_CLKS(16)) i_vts_top (.clock, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .va_mag, .vb_mag, .vc_mag, .iph_max_mag, .ineg_mag,
    .izero_mag, .vzero_mag, .vneg_detect, .ineg_present, .all_poles_dead,
    .vfail_block, .vfail_alarm, .cfail_block, .cfail_alarm, .irq);
  vts_meas_model i_vts_meas_model (.mode, .resid, .noise, .va_mag, .vb_mag,
    .vc_mag, .iph_max_mag, .ineg_mag, .izero_mag, .vzero_mag, .vneg_detect,
    .ineg_present, .all_poles_dead);
  // one single word transfer; address held until ready is seen
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clock);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // apply a scenario, check early quiet alarms, then settled outputs
  task automatic step(input int m, input int r);
    @(posedge clock);
    mode <= m[2:0];
    resid <= r[1:0];
    noise <= 8'($urandom);
    cc = (r == 1) && ctl[2];
    lat = (m == 1 || m == 2) || (!ctl[1] && lat);
    repeat (10) @(posedge clock);
    if (!plat) `CHK("valarm early", 1'b0, vfail_alarm)
    if (!pcc) `CHK("calarm early", 1'b0, cfail_alarm)
    repeat (70) @(posedge clock);
    pend = pend | {cc && !pcc, cc && !pcc, lat && !plat};
    `CHK("vblock", lat && ctl[0], vfail_block)
    `CHK("valarm", lat != 0, vfail_alarm)
    `CHK("cblock", cc != 0, cfail_block)
    `CHK("calarm", cc != 0, cfail_alarm)
    `CHK("irq", mask && pend != 0, irq)
    plat = lat;
    pcc = cc;
  endtask
  // read-to-clear status, then the level output must drop
  task automatic rd_irq;
    bus(0, VTS_OFS_IRQ, 0);
    `CHK("irq status", pend, q[3:1])
    pend = 0;
    repeat (3) @(posedge clock);
    `CHK("irq clear", 1'b0, irq)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence: reset values, settings, then each control mix
  initial
  begin
    void'($urandom(32'h2c21));
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    bus(0, VTS_OFS_CTRL, 0);
    `CHK("ctrl reset", VTS_CTRL_RST, q[2:0])
    bus(0, VTS_OFS_MASK, 0);
    `CHK("mask reset", 0, q)
    bus(0, 8'h30, 0);
    `CHK("unmapped", 0, q)
    for (int i = 0; i < 7; i++)
      bus(1, cfg_a[i], cfg_d[i]);
    bus(0, VTS_OFS_VPICK, 0);
    `CHK("pickup", 32'h1000, q)
    bus(1, VTS_OFS_MASK, 32'hf);
    mask = 1;
    for (int k = 0; k < 3; k++)
    begin
      ctl = ctls[k];
      bus(1, VTS_OFS_CTRL, ctl);
      for (int m = 1; m < 8; m++)
        step(m % 7, (m % 7) % 3);
      // a held manual latch keeps re-setting status, so clear it first
      if (!ctl[1])
      begin
        bus(1, VTS_OFS_CMD, 1);
        lat = 0;
        step(0, 0);
      end
      rd_irq();
    end
    // masked event still sets status but leaves irq low
    bus(1, VTS_OFS_MASK, 0);
    mask = 0;
    step(1, 0);
    rd_irq();
    finish_test();
  end
  // watchdog well past the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule
